// File: ddrb_pkg.sv
`default_nettype none
package ddrb_pkg;

	// ----------------------------------------
	// pin widths
	// ----------------------------------------
	localparam int BANKS = 8;
	localparam int BA_W  = 3;
	localparam int A_W   = 15;
	localparam int COL_W = 10;
	localparam int DQ_W  = 16;
	localparam int DM_W  = 2;

	// ----------------------------------------
	// command code {cs_n, ras_n, cas_n, we_n}
	// ----------------------------------------
	localparam logic [3:0] CMD_MRS = 4'h0;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_WR  = 4'h4;
	localparam logic [3:0] CMD_RD  = 4'h5;

	// ----------------------------------------
	// address fields
	// ----------------------------------------
	localparam int A_AP       = 10;  // auto precharge / all banks
	localparam int A_BC       = 12;  // on-the-fly: high selects eight beats
	localparam int MR0_BL_LSB = 0;
	localparam logic [BA_W-1:0] MR0_SEL = 3'h0;

	// ----------------------------------------
	// burst length modes and beat counts
	// ----------------------------------------
	localparam logic [1:0] BL_FIX8 = 2'h0;
	localparam logic [1:0] BL_OTF  = 2'h1;
	localparam logic [1:0] BL_FIX4 = 2'h2;
	localparam logic [3:0] LEN8    = 4'h8;
	localparam logic [3:0] LEN4    = 4'h4;

	// ----------------------------------------
	// states
	// ----------------------------------------
	typedef enum logic [1:0] {PWR_ON, PWR_APD, PWR_PPD, PWR_SR} ddrb_pwr_e;
	typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_PRE, RD_BURST} ddrb_rd_e;

endpackage : ddrb_pkg
`default_nettype wire

// File: ddrb_core.sv
`default_nettype none

// ----------------------------------------
// fifo
// ----------------------------------------
module ddrb_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 16
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wp;
	logic [AW:0]  rp;

	// pointers carry a wrap bit for honest full/empty
	assign in_ready_o  = !((wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]));
	assign out_valid_o = (wp != rp);
	assign out_data_o  = mem[rp[AW-1:0]];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wp <= '0;
			rp <= '0;
		end else begin
			if (in_valid_i && in_ready_o) begin
				mem[wp[AW-1:0]] <= in_data_i;
				wp              <= wp + 1'b1;
			end
			if (out_valid_o && out_ready_i)
				rp <= rp + 1'b1;
		end
	end
endmodule : ddrb_fifo

// ----------------------------------------
// dram die core
// ----------------------------------------
module ddrb_core
	import ddrb_pkg::*;
#(
	parameter int RD_LAT = 5,   // ck rises from read command to first beat
	parameter int MROW_W = 2,   // row bits kept in the storage array
	parameter int MCOL_W = 5,   // column bits kept in the storage array
	parameter int FIFO_D = 16
) (
	input  wire logic            ref_clk_i,
	input  wire logic            sys_rst_i,
	input  wire logic            reset_n_i,
	input  wire logic            ck_i,
	input  wire logic            cke_i,
	input  wire logic            cs_n_i,
	input  wire logic            ras_n_i,
	input  wire logic            cas_n_i,
	input  wire logic            we_n_i,
	input  wire logic            odt_i,
	input  wire logic [BA_W-1:0] ba_i,
	input  wire logic [A_W-1:0]  addr_i,
	input  wire logic [DM_W-1:0] dm_i,
	input  wire logic [DQ_W-1:0] dq_i,
	input  wire logic            dqs_i,
	output logic [DQ_W-1:0]      dq_o,
	output logic                 dq_oe_o,
	output logic                 dqs_o,
	output logic                 dqs_n_o,
	output logic                 dqs_oe_o,
	output logic [BANKS-1:0]     open_banks_o,
	output logic [1:0]           pwr_mode_o,
	output logic                 odt_en_o
);
	localparam int SW     = 9 + BA_W + A_W + DM_W + DQ_W;
	localparam int MEM_AW = BA_W + MROW_W + MCOL_W;

	// ----------------------------------------
	// pin synchroniser and ck edge finder
	// ----------------------------------------
	logic [SW-1:0] s1;
	logic [SW-1:0] s2;
	logic rstn_s, ck_s, cke_s, cs_s, ras_s, cas_s, we_s, odt_s, dqs_s;
	logic [BA_W-1:0] ba_s;
	logic [A_W-1:0]  addr_s;
	logic [DM_W-1:0] dm_s;
	logic [DQ_W-1:0] dq_s;
	logic ck_d, dqs_d, rst;

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			s1    <= '0;
			s2    <= '0;
			ck_d  <= 1'b0;
			dqs_d <= 1'b0;
		end else begin
			s1    <= {reset_n_i, ck_i, cke_i, cs_n_i, ras_n_i, cas_n_i,
				we_n_i, odt_i, dqs_i, ba_i, addr_i, dm_i, dq_i};
			s2    <= s1;
			ck_d  <= ck_s;
			dqs_d <= dqs_s;
		end
	end
	assign {rstn_s, ck_s, cke_s, cs_s, ras_s, cas_s, we_s, odt_s, dqs_s,
		ba_s, addr_s, dm_s, dq_s} = s2;
	assign rst = sys_rst_i || !rstn_s;

	logic ck_rise, ck_edge, dqs_rise, dqs_edge;
	assign ck_rise  = ck_s && !ck_d;
	assign ck_edge  = ck_s ^ ck_d;
	assign dqs_rise = dqs_s && !dqs_d;
	assign dqs_edge = dqs_s ^ dqs_d;

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	ddrb_pwr_e pwr;
	logic [3:0] cmd;
	logic cmd_take, cke_q, all_idle;
	logic [BANKS-1:0] bank_open;
	logic [A_W-1:0] bank_row [BANKS];
	logic [1:0] bl_mode;
	logic [3:0] cmd_len;

	assign cmd      = {cs_s, ras_s, cas_s, we_s};
	assign cmd_take = ck_rise && pwr == PWR_ON && cke_s && !cs_s;
	assign all_idle = (bank_open == '0);
	assign cmd_len  = (bl_mode == BL_FIX4 ||
		(bl_mode == BL_OTF && !addr_s[A_BC])) ? LEN4 : LEN8;

	// burst address: wraps inside the nibble or the octet
	function automatic logic [MEM_AW-1:0] mem_idx(
		input logic [BA_W-1:0]  b,
		input logic [A_W-1:0]   r,
		input logic [COL_W-1:0] c,
		input logic [2:0]       i,
		input logic             four
	);
		logic [COL_W-1:0] cc;
		cc = c;
		if (four)
			cc[1:0] = c[1:0] + i[1:0];
		else
			cc[2:0] = c[2:0] + i;
		mem_idx = {b, r[MROW_W-1:0], cc[MCOL_W-1:0]};
	endfunction : mem_idx

	// mode register: burst length field
	always_ff @(posedge ref_clk_i) begin
		if (rst)
			bl_mode <= BL_FIX8;
		else if (cmd_take && cmd == CMD_MRS && ba_s == MR0_SEL)
			bl_mode <= addr_s[MR0_BL_LSB +: 2];
	end

	// power modes, entered on a sampled falling clock enable
	always_ff @(posedge ref_clk_i) begin
		if (rst) begin
			pwr   <= PWR_ON;
			cke_q <= 1'b1;
		end else begin
			if (ck_rise)
				cke_q <= cke_s;
			case (pwr)
				PWR_ON: if (ck_rise && cke_q && !cke_s) begin
					if (!all_idle)
						pwr <= PWR_APD;
					else if (!cs_s && cmd == CMD_REF)
						pwr <= PWR_SR;
					else
						pwr <= PWR_PPD;
				end
				PWR_SR: if (cke_s)
					pwr <= PWR_ON; // exit does not wait for ck
				default: if (ck_rise && cke_s)
					pwr <= PWR_ON;
			endcase
		end
	end

	// ----------------------------------------
	// read and write burst state
	// ----------------------------------------
	ddrb_rd_e rd_st;
	logic [3:0] rd_cnt, rd_left, rd_len, fill_left, rd_beats;
	logic [2:0] fill_idx, wr_idx;
	logic [BA_W-1:0] rd_bank, wr_bank;
	logic [COL_W-1:0] rd_col, wr_col;
	logic rd_ap, wr_ap, rd_done, wr_done, rd_beat, wr_beat;
	logic wr_arm, wr_on, wr_four;
	logic [3:0] wr_left;
	logic [DQ_W-1:0] rd_word, fifo_out;
	logic fifo_in_rdy, fifo_in_vld, fifo_out_vld;

	assign rd_done = rd_st == RD_BURST && ck_edge && rd_left == '0;
	assign rd_beat = (rd_st == RD_PRE && ck_rise) ||
		(rd_st == RD_BURST && ck_edge && rd_left != '0);
	assign wr_beat = (wr_arm && dqs_rise) || (wr_on && dqs_edge);
	assign wr_done = wr_beat && wr_left == 4'h1;

	// bank table: banks open and close independently
	always_ff @(posedge ref_clk_i) begin
		if (rst) begin
			bank_open <= '0;
		end else begin
			if (rd_done && rd_ap)
				bank_open[rd_bank] <= 1'b0;
			if (wr_done && wr_ap)
				bank_open[wr_bank] <= 1'b0;
			if (cmd_take && cmd == CMD_PRE) begin
				if (addr_s[A_AP])
					bank_open <= '0;
				else
					bank_open[ba_s] <= 1'b0;
			end
			if (cmd_take && cmd == CMD_ACT) begin
				bank_open[ba_s] <= 1'b1;
				bank_row[ba_s]  <= addr_s;
			end
		end
	end

	// write capture on the strobe, mask per byte lane
	always_ff @(posedge ref_clk_i) begin
		if (rst) begin
			wr_arm  <= 1'b0;
			wr_on   <= 1'b0;
			wr_left <= '0;
			wr_idx  <= '0;
		end else if (cmd_take && cmd == CMD_WR) begin
			wr_arm  <= 1'b1;
			wr_on   <= 1'b0;
			wr_left <= cmd_len;
			wr_four <= (cmd_len == LEN4);
			wr_idx  <= '0;
			wr_bank <= ba_s;
			wr_col  <= addr_s[COL_W-1:0];
			wr_ap   <= addr_s[A_AP];
		end else if (wr_beat) begin
			wr_arm  <= 1'b0;
			wr_on   <= !wr_done;
			wr_left <= wr_left - 1'b1;
			wr_idx  <= wr_idx + 1'b1;
		end
	end

	// storage array, one generate lane per byte
	for (genvar b = 0; b < DM_W; b++) begin : g_lane
		logic [7:0] lane [2**MEM_AW];
		always_ff @(posedge ref_clk_i) begin
			if (wr_beat && !dm_s[b])
				lane[mem_idx(wr_bank, bank_row[wr_bank], wr_col,
					wr_idx, wr_four)] <= dq_s[b*8 +: 8];
		end
		assign rd_word[b*8 +: 8] = lane[mem_idx(rd_bank,
			bank_row[rd_bank], rd_col, fill_idx, rd_len == LEN4)];
	end

	// core fetch into the fifo; a write beat stalls it
	assign fifo_in_vld = fill_left != '0 && !wr_beat;
	always_ff @(posedge ref_clk_i) begin
		if (rst) begin
			fill_left <= '0;
			fill_idx  <= '0;
		end else if (rd_st == RD_IDLE && cmd_take && cmd == CMD_RD) begin
			fill_left <= cmd_len;
			fill_idx  <= '0;
		end else if (fifo_in_vld && fifo_in_rdy) begin
			fill_left <= fill_left - 1'b1;
			fill_idx  <= fill_idx + 1'b1;
		end
	end

	ddrb_fifo #(
		.W     (DQ_W),
		.DEPTH (FIFO_D)
	) u_fifo (
		.clk_i       (ref_clk_i),
		.rst_i       (rst),
		.in_valid_i  (fifo_in_vld),
		.in_ready_o  (fifo_in_rdy),
		.in_data_i   (rd_word),
		.out_valid_o (fifo_out_vld),
		.out_ready_i (rd_beat),
		.out_data_o  (fifo_out)
	);

	// read pins: latency, preamble, one beat per ck edge
	always_ff @(posedge ref_clk_i) begin
		if (rst) begin
			rd_st    <= RD_IDLE;
			rd_cnt   <= '0;
			rd_left  <= '0;
			rd_len   <= LEN8;
			dq_o     <= '0;
			dq_oe_o  <= 1'b0;
			dqs_o    <= 1'b0;
			dqs_n_o  <= 1'b1;
			dqs_oe_o <= 1'b0;
		end else begin
			case (rd_st)
				RD_IDLE: if (cmd_take && cmd == CMD_RD) begin
					rd_st   <= RD_WAIT;
					rd_cnt  <= 4'(RD_LAT - 1);
					rd_left <= cmd_len;
					rd_len  <= cmd_len;
					rd_bank <= ba_s;
					rd_col  <= addr_s[COL_W-1:0];
					rd_ap   <= addr_s[A_AP];
				end
				RD_WAIT: if (ck_rise) begin
					if (rd_cnt <= 4'h1) begin
						rd_st    <= RD_PRE;
						dqs_oe_o <= 1'b1;
						dqs_o    <= 1'b0;
						dqs_n_o  <= 1'b1;
					end else
						rd_cnt <= rd_cnt - 1'b1;
				end
				RD_PRE: if (ck_rise)
					rd_st <= RD_BURST;
				RD_BURST: if (rd_done) begin
					rd_st    <= RD_IDLE;
					dq_oe_o  <= 1'b0;
					dqs_oe_o <= 1'b0;
					dqs_o    <= 1'b0;
					dqs_n_o  <= 1'b1;
				end
				default: rd_st <= RD_IDLE;
			endcase
			if (rd_beat) begin
				dq_o    <= fifo_out_vld ? fifo_out : '0;
				dq_oe_o <= 1'b1;
				dqs_o   <= ck_s;
				dqs_n_o <= !ck_s;
				rd_left <= rd_left - 1'b1;
			end
		end
	end

	// ----------------------------------------
	// status outputs
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (rst) begin
			open_banks_o <= '0;
			pwr_mode_o   <= PWR_ON;
			odt_en_o     <= 1'b0;
		end else begin
			open_banks_o <= bank_open;
			pwr_mode_o   <= pwr;
			if (ck_rise)
				odt_en_o <= odt_s && cke_s;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (rst || rd_st == RD_IDLE)
			rd_beats <= '0;
		else if (rd_beat)
			rd_beats <= rd_beats + 1'b1;
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst);

	a_desel_masked: assert property (ck_rise && cs_s && !rd_done && !wr_done
		|=> $stable(bank_open)) else $error("deselect changed banks");
	a_act_opens: assert property (cmd_take && cmd == CMD_ACT
		|=> bank_open[$past(ba_s)]) else $error("row not opened");
	a_pd_active: assert property (ck_rise && pwr == PWR_ON && cke_q &&
		!cke_s && !all_idle |=> pwr == PWR_APD)
		else $error("active power-down missed");
	a_sr_entry: assert property (ck_rise && pwr == PWR_ON && cke_q &&
		!cke_s && all_idle && !cs_s && cmd == CMD_REF |=> pwr == PWR_SR)
		else $error("self refresh missed");
	a_rd_preamble: assert property (rd_st == RD_PRE
		|-> dqs_oe_o && !dqs_o) else $error("bad read preamble");
	a_rd_edge_align: assert property (rd_st == RD_BURST &&
		$changed(dq_o) |-> $changed(dqs_o))
		else $error("read data not edge aligned");
	a_rd_beat_count: assert property (rd_done |-> rd_beats == rd_len)
		else $error("wrong read beat count");
	a_ap_close: assert property (rd_done && rd_ap
		|=> !bank_open[$past(rd_bank)])
		else $error("auto precharge left row open");
	a_fill_stall: assert property (fifo_in_vld && !fifo_in_rdy
		|=> $stable(fill_left)) else $error("fifo overrun");
endmodule : ddrb_core
`default_nettype wire

// File: ddrb_host_model.sv
`default_nettype none
// ----------------------------------------
// host controller model
// ----------------------------------------
module ddrb_host_model
	import ddrb_pkg::*;
(
	output logic                 ck_o,
	output logic                 cke_o,
	output logic [3:0]           cmd_o,
	output logic                 odt_o,
	output logic [BA_W-1:0]      ba_o,
	output logic [A_W-1:0]       addr_o,
	output logic [DM_W-1:0]      dm_o,
	output logic [DQ_W-1:0]      dq_o,
	output logic                 dqs_o,
	input  wire logic [DQ_W-1:0] dev_dq_i,
	input  wire logic            dev_dq_oe_i,
	input  wire logic            dev_dqs_i,
	input  wire logic            dev_dqs_oe_i
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [DQ_W-1:0] dq_h;
	logic            dqs_h;
	int              n_rise;

	// free running link clock, phase unrelated to the ref clock
	initial begin
		ck_o = 1'b0;
		n_rise = 0;
		cke_o = 1'b1;
		cmd_o = 4'hF;
		odt_o = 1'b1;   // single rank: termination enable tied high
		ba_o = '0;
		addr_o = '0;
		dm_o = '0;
		dq_h = 16'h0000;
		dqs_h = 1'b1;
		#7;
		forever begin
			#100;
			if (!ck_o) n_rise++;
			ck_o = ~ck_o;
		end
	end

	// released lines show the inverse of their last level
	always @(negedge dev_dqs_oe_i) begin
		dq_h = ~dev_dq_i;
		dqs_h = ~dev_dqs_i;
	end

	assign dq_o  = dev_dq_oe_i ? dev_dq_i : dq_h;
	assign dqs_o = dev_dqs_oe_i ? dev_dqs_i : dqs_h;

	// one command per ck rise: set at ck fall, held over the rise
	task automatic cmd(input logic [3:0] c, input logic [BA_W-1:0] b,
		input logic [A_W-1:0] a, input logic ke);
		@(negedge ck_o);
		cmd_o = c;
		ba_o = b;
		addr_o = a;
		cke_o = ke;
		@(posedge ck_o);
		@(negedge ck_o);
		cmd_o = 4'hF;
	endtask : cmd

	task automatic idle(input int n);
		repeat (n) @(posedge ck_o);
	endtask : idle

	// write burst: low preamble, then strobe edges centred in each eye
	task automatic wburst(input logic [DQ_W-1:0] d [8],
		input logic [DM_W-1:0] m [8], input int n);
		dqs_h = 1'b0;
		#100;
		for (int k = 0; k < n; k++) begin
			dq_h = d[k];
			dm_o = m[k];
			#50 dqs_h = ~dqs_h;
			#50;
		end
		#50;
		dm_o = '0;
		dq_h = ~dq_h;
		dqs_h = ~dqs_h;
	endtask : wburst

endmodule : ddrb_host_model
`default_nettype wire

// File: ddr3_sdram_burst_interface_tb_top.sv
`default_nettype none
module ddr3_sdram_burst_interface_tb_top
	import ddrb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int RDL = 5;

	logic                 ref_clk_i;
	logic                 sys_rst_i;
	logic                 reset_n = 1'b1;
	logic                 ck;
	logic                 cke;
	logic                 odt;
	logic [3:0]           cmd;
	logic [BA_W-1:0]      ba;
	logic [A_W-1:0]       addr;
	logic [DM_W-1:0]      dm;
	logic [DQ_W-1:0]      dq_w;
	logic [DQ_W-1:0]      dq_o;
	logic                 dqs_w;
	logic                 dq_oe;
	logic                 dqs;
	logic                 dqs_n;
	logic                 dqs_oe;
	logic [BANKS-1:0]     open_banks;
	logic [1:0]           pwr;
	logic                 odt_en;
	logic [DQ_W-1:0]      mem [32];
	int                   n_mismatch;
	int                   checks_done;

	// ----------------------------------------
	// clock, partner and device
	// ----------------------------------------
	initial begin
		ref_clk_i = 1'b0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end

	ddrb_host_model host (.ck_o(ck), .cke_o(cke), .cmd_o(cmd), .odt_o(odt),
		.ba_o(ba), .addr_o(addr), .dm_o(dm), .dq_o(dq_w), .dqs_o(dqs_w),
		.dev_dq_i(dq_o), .dev_dq_oe_i(dq_oe), .dev_dqs_i(dqs),
		.dev_dqs_oe_i(dqs_oe));

	ddrb_core #(.RD_LAT(RDL)) DUT (.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i), .reset_n_i(reset_n), .ck_i(ck), .cke_i(cke),
		.cs_n_i(cmd[3]), .ras_n_i(cmd[2]), .cas_n_i(cmd[1]), .we_n_i(cmd[0]),
		.odt_i(odt), .ba_i(ba), .addr_i(addr), .dm_i(dm), .dq_i(dq_w),
		.dqs_i(dqs_w), .dq_o(dq_o), .dq_oe_o(dq_oe), .dqs_o(dqs),
		.dqs_n_o(dqs_n), .dqs_oe_o(dqs_oe), .open_banks_o(open_banks),
		.pwr_mode_o(pwr), .odt_en_o(odt_en));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic close_out();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : close_out

	// bounded wait for the strobe enable (0) or the strobe itself (1)
	task automatic wait_high(input int which);
		int w;
		w = 0;
		while ((which ? dqs : dqs_oe) !== 1'b1) begin
			@(negedge ref_clk_i);
			w++;
			if (w > 400) begin
				n_mismatch++;
				$display("mismatch at %0t: wait timed out", $time);
				close_out();
			end
		end
	endtask : wait_high

	// column of beat k: eight beats wrap col[2:0], four wrap col[1:0]
	function automatic logic [4:0] colof(input logic [A_W-1:0] a,
		input int k, input int n);
		logic [4:0] c;
		c = a[4:0];
		if (n == 8) c[2:0] = c[2:0] + 3'(k);
		else c[1:0] = c[1:0] + 2'(k);
		return c;
	endfunction : colof

	// write to bank 3, upper byte masked on beat mb, expected array kept
	task automatic do_write(input logic [A_W-1:0] a, input int n,
		input logic [15:0] base, input int mb);
		logic [DQ_W-1:0] d [8];
		logic [DM_W-1:0] m [8];
		logic [4:0]      c;
		for (int k = 0; k < 8; k++) begin
			d[k] = base + 16'(k);
			m[k] = (k == mb) ? 2'h2 : 2'h0;
			c = colof(a, k, n);
			if (k < n) mem[c][7:0] = d[k][7:0];
			if (k < n && k != mb) mem[c][15:8] = d[k][15:8];
		end
		host.cmd(CMD_WR, 3'h3, a, 1'b1);
		host.wburst(d, m, n);
		host.idle(2);
	endtask : do_write

	// read from bank 3, optionally activating bank ab during the read latency
	task automatic do_read(input logic [A_W-1:0] a, input int n,
		input int ab);
		int take;
		host.cmd(CMD_RD, 3'h3, a, 1'b1);
		take = host.n_rise;
		if (ab >= 0) host.cmd(CMD_ACT, 3'(ab), 15'h0002, 1'b1);
		wait_high(0);
		check(16'(dqs), 16'h0000);
		wait_high(1);
		check(16'(host.n_rise - take), 16'(RDL));
		for (int k = 0; k < n; k++) begin
			check(dq_o, mem[colof(a, k, n)]);
			check(16'({dq_oe, dqs_oe, dqs, dqs_n}),
				16'({2'h3, ~k[0], k[0]}));
			repeat (4) @(negedge ref_clk_i);
		end
		check(16'({dq_oe, dqs_oe}), 16'h0000);
	endtask : do_read

	// cke level with command c, then settle two ck rises
	task automatic set_cke(input logic v, input logic [3:0] c);
		host.cmd(c, 3'h0, 15'h0000, v);
		host.idle(2);
	endtask : set_cke

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		check(16'({dq_oe, dqs_oe, dqs, dqs_n, odt_en}), 16'h0002);
		check(16'({open_banks, pwr}), 16'h0000);
		check(dq_o, 16'h0000);
	endtask : t_reset

	task automatic t_activate();
		host.cmd(CMD_MRS, 3'h0, {13'h0000, BL_OTF}, 1'b1);
		host.cmd(CMD_ACT, 3'h3, 15'h0001, 1'b1);
		host.idle(1);
		check(16'(open_banks), 16'h0008);
		host.cmd(4'h8 | CMD_ACT, 3'h5, 15'h0001, 1'b1);
		host.idle(1);
		check(16'(open_banks), 16'h0008);
		check(16'(odt_en), 16'h0001);
	endtask : t_activate

	task automatic t_bursts();
		do_write(15'h1000, 8, 16'hA5C0, 9);
		do_write(15'h0005, 4, 16'h3C10, 1);
		do_read(15'h1003, 8, -1);
		do_read(15'h0406, 4, 1);
		host.idle(1);
		check(16'(open_banks), 16'h0002);
	endtask : t_bursts

	task automatic t_power();
		set_cke(1'b0, 4'hF);
		check(16'({pwr, odt_en}), 16'({PWR_APD, 1'b0}));
		set_cke(1'b1, 4'hF);
		check(16'(pwr), 16'(PWR_ON));
		host.cmd(CMD_PRE, 3'h1, 15'h0000, 1'b1);
		host.idle(1);
		check(16'(open_banks), 16'h0000);
		set_cke(1'b0, 4'hF);
		check(16'(pwr), 16'(PWR_PPD));
		set_cke(1'b1, 4'hF);
		set_cke(1'b0, CMD_REF);
		check(16'(pwr), 16'(PWR_SR));
		set_cke(1'b1, 4'hF);
		check(16'(pwr), 16'(PWR_ON));
	endtask : t_power

	// reset pin pulsed mid-run: rows close, burst mode back to fixed eight
	task automatic t_pin_reset();
		host.cmd(CMD_ACT, 3'h2, 15'h0001, 1'b1);
		host.idle(1);
		check(16'(open_banks), 16'h0004);
		@(negedge ref_clk_i);
		reset_n = 1'b0;
		repeat (6) @(negedge ref_clk_i);
		check(16'({open_banks, pwr, odt_en}), 16'h0000);
		check(16'({dq_oe, dqs_oe, dqs, dqs_n}), 16'h0001);
		reset_n = 1'b1;
		repeat (4) @(negedge ref_clk_i);
		host.cmd(CMD_ACT, 3'h3, 15'h0001, 1'b1);
		host.idle(1);
		check(16'(open_banks), 16'h0008);
		do_write(15'h0000, 8, 16'h5A30, 2);
		do_read(15'h0002, 8, -1);
		host.cmd(CMD_MRS, 3'h0, {13'h0000, BL_FIX4}, 1'b1);
		do_read(15'h1001, 4, -1);
	endtask : t_pin_reset

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		n_mismatch = 0;
		checks_done = 0;
		sys_rst_i = 1'b1;
		repeat (6) @(negedge ref_clk_i);
		t_reset();
		sys_rst_i = 1'b0;
		repeat (4) @(negedge ref_clk_i);
		t_activate();
		t_bursts();
		t_power();
		t_pin_reset();
		close_out();
	end

endmodule : ddr3_sdram_burst_interface_tb_top
`default_nettype wire
